/* core/adm_pkg.sv */
`default_nettype none
package adm_pkg;

	// ------------------------------------------------------------
	// register map (word index on the plain register port)
	// ------------------------------------------------------------
	localparam logic [1:0]  ADDR_MODE   = 2'h0;
	localparam logic [1:0]  ADDR_GPO    = 2'h1;
	localparam logic [1:0]  ADDR_ERR    = 2'h2;
	localparam logic [1:0]  ADDR_SERVO  = 2'h3;
	localparam logic [15:0] MODE_RESET  = 16'h0000;
	localparam logic [7:0]  GPO_RESET   = 8'h00;
	localparam logic [1:0]  SERVO_RESET = 2'h0;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int ERR_ALARM_BIT     = 14;
	localparam int SERVO_ALM_EN_BIT  = 0;
	localparam int SERVO_INP_POL_BIT = 1;
	localparam int FE_SERVO_GRP      = 2;
	localparam int FE_JOG_GRP        = 3;
	localparam int OUT_SRISE = 0;
	localparam int OUT_SFALL = 1;
	localparam int OUT_PLUS_COMPARE_FLAG  = 2;
	localparam int OUT_MINUS_COMPARE_FLAG  = 3;
	localparam int OUT_DRIVE = 4;
	localparam int OUT_ACCEL = 5;
	localparam int OUT_CONST = 6;
	localparam int OUT_DECEL = 7;

	// ------------------------------------------------------------
	// filter timing: shortest delay, longer settings scale by 2^(n+6)
	// ------------------------------------------------------------
	localparam int FILT_BASE_NS   = 2000;
	localparam int CLK_PERIOD_NS  = 100;
	localparam int FILT_BASE_CYC  = (FILT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_SHIFT_OFS = 6;
	localparam int FILT_CNT_W     = 18;

	typedef enum logic [1:0] {
		EXT_OFF   = 2'h0,
		EXT_CONT  = 2'h1,
		EXT_FIXED = 2'h2,
		EXT_HAND  = 2'h3
	} adm_ext_mode_type;

	typedef struct packed {
		logic [2:0]       filt_time;
		logic [4:0]       filt_en;
		logic             out_sel;
		logic             variable_ring_enable;
		logic             tri_prev;
		adm_ext_mode_type ext_mode;
		logic             s_curve;
		logic             sep_decel;
		logic             manual_decel;
	} adm_mode_type;

	typedef struct packed {
		logic srise;
		logic sfall;
		logic driving;
		logic accel;
		logic const_spd;
		logic decel;
	} adm_drive_status_type;

	typedef struct packed {
		logic cont_plus;
		logic cont_minus;
		logic start_plus;
		logic start_minus;
	} adm_jog_req_type;

endpackage
`default_nettype wire

/* core/adm_top.sv */
`timescale 1ns/1ps
`default_nettype none

module adm_top #(
	parameter logic [17:0] FILT_BASE_CYC = 18'(adm_pkg::FILT_BASE_CYC)
) (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_b,
	// register port
	input  wire logic [1:0]                    reg_addr,
	input  wire logic [15:0]                   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output var  logic [15:0]                   reg_rdata,
	// pins from servo driver and jog switches (active low jog)
	input  wire logic                          servo_alarm_input,
	input  wire logic                          in_position_input,
	input  wire logic                          jog_plus_input,
	input  wire logic                          jog_minus_input,
	output var  logic [7:0]                    axis_output_pins,
	// from the pulse engine
	input  wire adm_pkg::adm_drive_status_type drive_status,
	input  wire logic [31:0]                   pos_count,
	input  wire logic [31:0]                   comp_plus,
	input  wire logic [31:0]                   comp_minus,
	input  wire logic [15:0]                   accel_rate,
	input  wire logic [15:0]                   decel_rate,
	input  wire logic                          auto_decel_hit,
	input  wire logic                          manual_decel_hit,
	// to the pulse engine
	output var  logic [15:0]                   ramp_rate,
	output var  logic                          decel_start,
	output var  logic                          s_curve_en,
	output var  logic                          tri_prevent_en,
	output var  logic                          variable_ring_enable_en,
	output var  logic                          alarm_stop,
	output var  logic                          in_position_active,
	output var  adm_pkg::adm_jog_req_type      jog_req
);

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_s1;
	logic rst_n;

	// async assert, sync release
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	adm_pkg::adm_mode_type mode;
	logic [7:0]            gpo;
	logic [1:0]            servo_cfg;
	logic                  alarm_flag;

	// mode register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= adm_pkg::adm_mode_type'(adm_pkg::MODE_RESET);
		end else if (reg_wr && reg_addr == adm_pkg::ADDR_MODE) begin
			mode <= adm_pkg::adm_mode_type'(reg_wdata);
		end
	end

	// general output and servo config
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gpo       <= adm_pkg::GPO_RESET;
			servo_cfg <= adm_pkg::SERVO_RESET;
		end else if (reg_wr) begin
			if (reg_addr == adm_pkg::ADDR_GPO) begin
				gpo <= reg_wdata[7:0];
			end
			if (reg_addr == adm_pkg::ADDR_SERVO) begin
				servo_cfg <= reg_wdata[1:0];
			end
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				adm_pkg::ADDR_MODE:  reg_rdata <= 16'(mode);
				adm_pkg::ADDR_GPO:   reg_rdata <= {8'h00, gpo};
				adm_pkg::ADDR_ERR:   reg_rdata <= 16'(alarm_flag) << adm_pkg::ERR_ALARM_BIT;
				adm_pkg::ADDR_SERVO: reg_rdata <= {14'h0000, servo_cfg};
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers and noise filters
	// ------------------------------------------------------------
	// index 0 alarm, 1 in-position, 2 jog plus, 3 jog minus
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic [3:0] pin_f;

	// idle high so no false jog edge after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= 4'hF;
			pin_s2 <= 4'hF;
		end else begin
			pin_s1 <= {jog_minus_input, jog_plus_input, in_position_input, servo_alarm_input};
			pin_s2 <= pin_s1;
		end
	end

	// settle time in cycles for a time constant code
	function automatic logic [17:0] filt_limit(input logic [2:0] code);
		if (code == 3'h0) begin
			filt_limit = FILT_BASE_CYC;
		end else begin
			filt_limit = FILT_BASE_CYC << (32'(code) + adm_pkg::FILT_SHIFT_OFS);
		end
	endfunction

	logic [17:0] filt_max;
	assign filt_max = filt_limit(mode.filt_time);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_filt
			logic [17:0] cnt;
			logic        grp_en;
			// alarm and in-position share one enable, jogs the other
			assign grp_en = (gi < 2) ? mode.filt_en[adm_pkg::FE_SERVO_GRP]
			                         : mode.filt_en[adm_pkg::FE_JOG_GRP];
			// a level must hold for the whole time before it passes
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					cnt      <= 18'h00000;
					pin_f[gi] <= 1'b1;
				end else if (!grp_en || pin_s2[gi] == pin_f[gi]) begin
					cnt       <= 18'h00000;
					pin_f[gi] <= pin_s2[gi];
				end else if (cnt >= filt_max - 18'h00001) begin
					cnt       <= 18'h00000;
					pin_f[gi] <= pin_s2[gi];
				end else begin
					cnt <= cnt + 18'h00001;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// servo alarm and in-position
	// ------------------------------------------------------------
	logic alarm_hit;
	assign alarm_hit = servo_cfg[adm_pkg::SERVO_ALM_EN_BIT] && !pin_f[0];

	// alarm shows while present and enabled; drive is held stopped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_flag <= 1'b0;
			alarm_stop <= 1'b0;
		end else begin
			alarm_flag <= alarm_hit;
			alarm_stop <= alarm_hit;
		end
	end

	// polarity bit 0: low is active
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_position_active <= 1'b0;
		end else begin
			in_position_active <= servo_cfg[adm_pkg::SERVO_INP_POL_BIT] ? pin_f[1] : !pin_f[1];
		end
	end

	// ------------------------------------------------------------
	// external jog inputs
	// ------------------------------------------------------------
	logic jp_q;
	logic jm_q;
	logic jp_fall;
	logic jp_rise;
	logic jm_fall;

	// edge history of the filtered jog levels
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			jp_q <= 1'b1;
			jm_q <= 1'b1;
		end else begin
			jp_q <= pin_f[2];
			jm_q <= pin_f[3];
		end
	end

	assign jp_fall = jp_q && !pin_f[2];
	assign jp_rise = !jp_q && pin_f[2];
	assign jm_fall = jm_q && !pin_f[3];

	// starts are single-cycle pulses; alarm blocks every request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			jog_req <= '0;
		end else begin
			jog_req <= '0;
			if (!alarm_hit) begin
				unique case (mode.ext_mode)
					adm_pkg::EXT_OFF: begin
					end
					adm_pkg::EXT_CONT: begin
						jog_req.cont_plus  <= !pin_f[2];
						jog_req.cont_minus <= !pin_f[3];
					end
					adm_pkg::EXT_FIXED: begin
						jog_req.start_plus  <= jp_fall;
						jog_req.start_minus <= jm_fall;
					end
					adm_pkg::EXT_HAND: begin
						jog_req.start_plus  <= jp_rise && !pin_f[3];
						jog_req.start_minus <= jp_fall && !pin_f[3];
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// ramp configuration to the pulse engine
	// ------------------------------------------------------------
	// rate and decel point picked per cycle so a phase change lands on the next cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ramp_rate      <= 16'h0000;
			decel_start    <= 1'b0;
			s_curve_en     <= 1'b0;
			tri_prevent_en <= 1'b0;
			variable_ring_enable_en       <= 1'b0;
		end else begin
			ramp_rate      <= (mode.sep_decel && drive_status.decel) ? decel_rate : accel_rate;
			decel_start    <= mode.manual_decel ? manual_decel_hit : auto_decel_hit;
			s_curve_en     <= mode.s_curve;
			tri_prevent_en <= mode.tri_prev;
			variable_ring_enable_en       <= mode.variable_ring_enable;
		end
	end

	// ------------------------------------------------------------
	// output pins
	// ------------------------------------------------------------
	logic [7:0] status_pins;
	logic       run;
	assign run = drive_status.driving;

	// compare flags are signed; phase pins only during a drive
	always_comb begin
		status_pins = 8'h00;
		status_pins[adm_pkg::OUT_SRISE] = drive_status.srise;
		status_pins[adm_pkg::OUT_SFALL] = drive_status.sfall;
		status_pins[adm_pkg::OUT_PLUS_COMPARE_FLAG]  = $signed(pos_count) >= $signed(comp_plus);
		status_pins[adm_pkg::OUT_MINUS_COMPARE_FLAG]  = $signed(pos_count) < $signed(comp_minus);
		status_pins[adm_pkg::OUT_DRIVE] = run;
		status_pins[adm_pkg::OUT_ACCEL] = run && drive_status.accel;
		status_pins[adm_pkg::OUT_CONST] = run && drive_status.const_spd;
		status_pins[adm_pkg::OUT_DECEL] = run && drive_status.decel;
	end

	// pins low from reset until software writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			axis_output_pins <= 8'h00;
		end else begin
			axis_output_pins <= mode.out_sel ? status_pins : gpo;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_pins_gpo: assert property (!mode.out_sel |=> axis_output_pins == $past(gpo))
		else $error("pins do not follow output register");
	a_pins_drive: assert property (mode.out_sel |=> axis_output_pins[4] == $past(run))
		else $error("drive pin wrong");
	a_pins_srise: assert property (mode.out_sel ##0 drive_status.srise |=> axis_output_pins[0])
		else $error("S-curve rising pin low");
	a_pins_sfall: assert property (mode.out_sel ##0 !drive_status.sfall |=> !axis_output_pins[1])
		else $error("S-curve falling pin high");
	a_cmp_plus: assert property (mode.out_sel ##0 $signed(pos_count) >= $signed(comp_plus)
		|=> axis_output_pins[2])
		else $error("plus compare pin low");
	a_cmp_minus: assert property (mode.out_sel ##0 $signed(pos_count) >= $signed(comp_minus)
		|=> !axis_output_pins[3])
		else $error("minus compare pin high");
	a_phase_idle: assert property (mode.out_sel ##0 !run |=> axis_output_pins[7:5] == 3'h0)
		else $error("phase pins high without drive");
	a_rate_pick: assert property (mode.sep_decel ##0 drive_status.decel |=> ramp_rate == $past(decel_rate))
		else $error("decel rate not selected");
	a_rate_shared: assert property (!mode.sep_decel |=> ramp_rate == $past(accel_rate))
		else $error("accel rate not shared");
	a_alarm_stop: assert property (alarm_hit |=> alarm_stop && alarm_flag && jog_req == '0)
		else $error("alarm did not stop drive");
	a_alarm_off: assert property (!servo_cfg[0] |=> !alarm_stop)
		else $error("disabled alarm stopped drive");
	a_jog_fixed: assert property (mode.ext_mode == adm_pkg::EXT_FIXED && !alarm_hit ##0 jp_fall
		|=> jog_req.start_plus ##1 !jog_req.start_plus)
		else $error("fixed jog start missing");
	a_jog_hand: assert property (mode.ext_mode == adm_pkg::EXT_HAND && !alarm_hit ##0 jp_rise && !pin_f[3]
		|=> jog_req.start_plus && !jog_req.start_minus)
		else $error("hand pulser plus start missing");
	a_jog_cont: assert property (mode.ext_mode == adm_pkg::EXT_CONT && !alarm_hit
		|=> jog_req.cont_minus == !$past(pin_f[3]))
		else $error("continuous jog wrong");

endmodule
`default_nettype wire

/* sim/adm_far_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// far side: servo driver and jog switches
// ------------------------------------------------------------
module adm_far_model (
	// clock
	input  wire logic clk,
	// requests from the bench
	input  wire logic alarm_on,
	input  wire logic inpos_lvl,
	input  wire logic jp_low,
	input  wire logic jm_low,
	input  wire logic slow,
	// pins toward the block
	output var  logic servo_alarm_input,
	output var  logic in_position_input,
	output var  logic jog_plus_input,
	output var  logic jog_minus_input
);
	logic [3:0] stage1 = 4'hB;
	logic [3:0] stage2 = 4'hB;

	// pins settle one edge late, or two for a sluggish driver
	always_ff @(posedge clk) begin
		stage1 <= {~alarm_on, inpos_lvl, ~jp_low, ~jm_low};
		stage2 <= stage1;
	end

	// active low alarm and jog pins: idle switches and a healthy driver hold them high; in-position follows inpos_lvl
	assign {servo_alarm_input, in_position_input, jog_plus_input, jog_minus_input} = slow ? stage2 : stage1;
endmodule
`default_nettype wire

/* sim/tb_axis_drive_mode_control.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_axis_drive_mode_control;
	logic                          clk, rst_b, reg_wr, reg_rd, auto_hit, man_hit;
	logic [1:0]                    reg_addr;
	logic [15:0]                   reg_wdata, reg_rdata, accel_rate, decel_rate, ramp_rate, d;
	logic [7:0]                    pins;
	logic signed [31:0]            pos, cp, cm;
	adm_pkg::adm_drive_status_type ds;
	adm_pkg::adm_jog_req_type      jog;
	logic                          dstart, s_en, tri_en, vr_en, alm_stop, inpos_act;
	logic                          alarm_on, inpos_lvl, jp_low, jm_low, slow;
	wire logic                     sa, ip, jp, jm;
	int                            bad_count, checks, n_sp, n_sm, n_ds, n_al;

	adm_top #(.FILT_BASE_CYC(18'h2)) DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.servo_alarm_input(sa), .in_position_input(ip), .jog_plus_input(jp), .jog_minus_input(jm),
		.axis_output_pins(pins), .drive_status(ds), .pos_count(pos), .comp_plus(cp), .comp_minus(cm),
		.accel_rate(accel_rate), .decel_rate(decel_rate), .auto_decel_hit(auto_hit),
		.manual_decel_hit(man_hit), .ramp_rate(ramp_rate), .decel_start(dstart), .s_curve_en(s_en),
		.tri_prevent_en(tri_en), .variable_ring_enable_en(vr_en), .alarm_stop(alm_stop),
		.in_position_active(inpos_act), .jog_req(jog));

	adm_far_model FAR (.clk(clk), .alarm_on(alarm_on), .inpos_lvl(inpos_lvl), .jp_low(jp_low),
		.jm_low(jm_low), .slow(slow), .servo_alarm_input(sa), .in_position_input(ip),
		.jog_plus_input(jp), .jog_minus_input(jm));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(logic [1:0] a, logic [15:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rchk(string what, logic [1:0] a, logic [15:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(what, exp, reg_rdata);
	endtask

	// counts cycles each event stands high, so a pulse must last exactly one
	task automatic watch(int n);
		{n_sp, n_sm, n_ds, n_al} = '0;
		repeat (n) begin
			@(posedge clk);
			#1;
			n_sp += jog.start_plus;
			n_sm += jog.start_minus;
			n_ds += dstart;
			n_al += alm_stop;
		end
	endtask

	task automatic jog_set(logic p, logic m);
		@(posedge clk);
		jp_low <= p;
		jm_low <= m;
		watch(10);
	endtask

	function automatic logic [7:0] exp_st(adm_pkg::adm_drive_status_type s);
		return {s.decel & s.driving, s.const_spd & s.driving, s.accel & s.driving, s.driving,
			pos < cm, pos >= cp, s.sfall, s.srise};
	endfunction

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		rchk("mode", adm_pkg::ADDR_MODE, adm_pkg::MODE_RESET);
		check("pins", 8'h00, pins);
		wr(adm_pkg::ADDR_MODE, 16'h0064);
		watch(2);
		check("s_curve_en", 1'b1, s_en);
		check("tri_prevent_en", 1'b1, tri_en);
		check("variable_ring_enable_en", 1'b1, vr_en);
		rchk("mode", adm_pkg::ADDR_MODE, 16'h0064);
		// software clears triangle prevention before a continuous drive
		wr(adm_pkg::ADDR_MODE, 16'h0000);
		watch(2);
		check("ctl_bits", 3'h0, {s_en, tri_en, vr_en});
		wr(adm_pkg::ADDR_ERR, 16'hFFFF);
		rchk("err", adm_pkg::ADDR_ERR, 16'h0000);
		$display("test regs done");
	endtask

	task automatic t_pins;
		logic [5:0] tbl [8] = '{6'h20, 6'h10, 6'h08, 6'h0C, 6'h0A, 6'h09, 6'h04, 6'h00};
		wr(adm_pkg::ADDR_GPO, 16'h00A5);
		watch(2);
		check("pins", 8'hA5, pins);
		wr(adm_pkg::ADDR_MODE, 16'h0080);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			ds <= adm_pkg::adm_drive_status_type'(tbl[i]);
			pos <= i[0] ? -32'sd1 : 32'sd5;
			cp <= i[0] ? 32'sd0 : 32'sd5;
			cm <= i[0] ? 32'sd0 : 32'sd5;
			watch(2);
			check("pins", exp_st(ds), pins);
		end
		wr(adm_pkg::ADDR_MODE, 16'h0000);
		watch(2);
		check("pins", 8'hA5, pins);
		$display("test pins done");
	endtask

	task automatic t_ramp;
		for (int k = 0; k < 4; k++) begin
			// an asymmetric ramp needs the separate rate bit
			// odd passes also pick the programmed decel point
			wr(adm_pkg::ADDR_MODE, k[0] ? 16'h0003 : 16'h0000);
			ds <= adm_pkg::adm_drive_status_type'(k[1] ? 6'h09 : 6'h0C);
			watch(3);
			check("ramp_rate", (k == 3) ? 16'h2222 : 16'h1111, ramp_rate);
			for (int h = 0; h < 2; h++) begin
				@(posedge clk);
				auto_hit <= (h == 0);
				man_hit <= (h == 1);
				@(posedge clk);
				{auto_hit, man_hit} <= 2'b00;
				// the registered decel start stands only in this cycle
				#1;
				check("decel_start", (h == k[0]) ? 1 : 0, dstart);
				watch(4);
				check("decel_start_len", 0, n_ds);
			end
		end
		ds <= '0;
		$display("test ramp done");
	endtask

	task automatic t_servo;
		wr(adm_pkg::ADDR_MODE, 16'h0400);
		wr(adm_pkg::ADDR_SERVO, 16'h0001);
		alarm_on <= 1'b1;
		@(posedge clk);
		alarm_on <= 1'b0;
		watch(12);
		check("alarm_glitch", 0, n_al);
		slow <= 1'b1;
		alarm_on <= 1'b1;
		watch(12);
		check("alarm_stop", 1'b1, alm_stop);
		rchk("err", adm_pkg::ADDR_ERR, 16'h4000);
		wr(adm_pkg::ADDR_SERVO, 16'h0000);
		watch(6);
		check("alarm_stop", 1'b0, alm_stop);
		rchk("err", adm_pkg::ADDR_ERR, 16'h0000);
		alarm_on <= 1'b0;
		slow <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			wr(adm_pkg::ADDR_SERVO, 16'(k[1]) << 1);
			inpos_lvl <= k[0];
			watch(12);
			check("in_position", k[0] == k[1], inpos_act);
		end
		$display("test servo done");
	endtask

	task automatic t_jog;
		jog_set(1'b1, 1'b1);
		check("jog_off", 4'h0, jog);
		check("jog_off", 0, n_sp + n_sm);
		wr(adm_pkg::ADDR_MODE, 16'h0008);
		jog_set(1'b1, 1'b0);
		check("jog_cont", 4'h8, jog);
		jog_set(1'b1, 1'b1);
		check("jog_cont", 4'hC, jog);
		jog_set(1'b0, 1'b0);
		check("jog_cont", 4'h0, jog);
		wr(adm_pkg::ADDR_MODE, 16'h0010);
		jog_set(1'b1, 1'b0);
		check("fixed_plus", 1, n_sp);
		check("fixed_minus", 0, n_sm);
		jog_set(1'b1, 1'b1);
		check("fixed_plus", 0, n_sp);
		check("fixed_minus", 1, n_sm);
		jog_set(1'b0, 1'b0);
		check("fixed_starts", 0, n_sp + n_sm);
		wr(adm_pkg::ADDR_MODE, 16'h0018);
		jog_set(1'b0, 1'b1);
		jog_set(1'b1, 1'b1);
		check("hand_plus", 0, n_sp);
		check("hand_minus", 1, n_sm);
		jog_set(1'b0, 1'b1);
		check("hand_plus", 1, n_sp);
		check("hand_minus", 0, n_sm);
		jog_set(1'b1, 1'b0);
		check("hand_starts", 0, n_sp + n_sm);
		jog_set(1'b0, 1'b0);
		check("hand_starts", 0, n_sp + n_sm);
		$display("test jog done");
	endtask

	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// the tests need about 370 cycles; give them forty times that
	initial begin
		#1500000;
		bad_count++;
		test_done;
	end

	initial begin
		{rst_b, reg_wr, reg_rd, auto_hit, man_hit, alarm_on, inpos_lvl, jp_low, jm_low, slow} = '0;
		{reg_addr, reg_wdata, pos, cp, cm, ds} = '0;
		accel_rate = 16'h1111;
		decel_rate = 16'h2222;
		{bad_count, checks} = '0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs;
		t_pins;
		t_ramp;
		t_servo;
		t_jog;
		test_done;
	end
endmodule
`default_nettype wire
